// ==== shared/pmrs_defs.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the supervisor
// Assumes: byte addresses on a 12-bit register port
// Notes: definitions only
`ifndef PMRS_DEFS_SVH
`define PMRS_DEFS_SVH

`define PMRS_ADDR_W 12
`define PMRS_OFF_TASK_CONST_LATENCY_TASK 12'h078
`define PMRS_OFF_TASK_LOWPOWER 12'h07C
`define PMRS_OFF_EVT_PFWARN 12'h108
`define PMRS_OFF_PIN_SELECT 12'h200
`define PMRS_OFF_RESET_REASON 12'h400
`define PMRS_OFF_PF_CONFIG 12'h510
`define PMRS_OFF_STATUS 12'h600
`define PMRS_OFF_RAM_BASE 12'h900
`define PMRS_RAM_STRIDE 12'h010

// reset reason bits
`define PMRS_RR_PIN 0
`define PMRS_RR_WDOG 1
`define PMRS_RR_SOFT 2
`define PMRS_RR_LOCKUP 3
`define PMRS_RR_WAKE 16
`define PMRS_RR_CTRLAP 17

// power-fail config fields
`define PMRS_PF_EN 0
`define PMRS_PF_THR_LSB 1
`define PMRS_PF_THR_W 4

// ram section fields
`define PMRS_RAM_POWER 0
`define PMRS_RAM_RETAIN 16
`define PMRS_RAM_RST 32'h0001_0001

// pin select fields
`define PMRS_PSEL_CONNECT 31
`define PMRS_PSEL_RST 32'h0000_0000

// minimum length of a pulsed reset
`define PMRS_RST_HOLD_NS 64
`define PMRS_CLK_NS 8

`endif

// ==== shared/pmrs_pkg.sv ====
// Purpose: types shared by the power mode and reset supervisor
// Assumes: nothing
// Notes: one bit per reset domain
package pmrs_pkg;

  typedef struct packed {
    logic reason;
    logic swdp;
    logic retained;
    logic wdt;
    logic debug;
    logic gpio;
    logic periph;
    logic cpu;
  } pmrs_domain_t;

  typedef struct packed {
    logic ram_access;
    logic ram_retain;
  } pmrs_ram_t;

endpackage : pmrs_pkg

// ==== verilog/pmrs_supervisor.sv ====
// Purpose: sub power mode, power-fail warning, ram section control and reset fan-out
// Assumes: ref_clk 125 MHz, pins and analog flags asynchronous, core and debug signals
//          on ref_clk
// Notes: nrst stands for the power-on path of the register file itself
//
// Behaviour
// (RULE_01) power-on comes up in System ON
// (RULE_02) sub mode applies only when all idle
// (RULE_03) constant-latency task selects constant latency
// (RULE_04) low-power task selects low power
// (RULE_05) System ON entry defaults to low power
// (RULE_06) enabled comparator warns when supply falls
// (RULE_07) warn also on enable or threshold raise
// (RULE_08) power-fail warning never causes reset
// (RULE_09) warning condition blocks nonvolatile writes
// (RULE_10) comparator off in System OFF, clock stopped
// (RULE_11) System OFF: ram inaccessible, retention field
// (RULE_12) System ON: power field gives access
// (RULE_13) reset reason register records latest source
// (RULE_14) power-on holds all until supply ready
// (RULE_15) selected capable reset pin gives pin reset
// (RULE_16) wake reset spares debug in debug mode
// (RULE_17) core request or control port: soft reset
// (RULE_18) lockup suppressed in debug; cpu/periph/gpio only
// (RULE_19) wake clears cpu, peripherals, debug only
// (RULE_20) watchdog reset, not in OFF, pin targets
// (RULE_21) brownout and power-on clear every domain
// (RULE_22) no reset source clears ram contents
// (RULE_23) sub mode held in one state bit
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_defs.svh"

module pmrs_supervisor
  import pmrs_pkg::*;
#(
  parameter int RAM_SECTIONS = 3,
  parameter int NUM_PINS = 32,
  parameter logic [NUM_PINS-1:0] RESET_PIN_CAPABLE = 32'h0000_0001
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [`PMRS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // asynchronous analog flags and pins
  input wire logic supply_ok,
  input wire logic regulators_ok,
  input wire logic brownout_n,
  input wire logic supply_below_threshold,
  input wire logic high_freq_clock_running,
  input wire logic [NUM_PINS-1:0] pin_levels,
  // core, debug and system state
  input wire logic cpu_idle,
  input wire logic periph_idle,
  input wire logic system_off,
  input wire logic wake_from_off,
  input wire logic debug_mode,
  input wire logic system_reset_request_bit,
  input wire logic control_access_port_reset,
  input wire logic watchdog_timeout,
  input wire logic cpu_lockup,
  // mode and supervisor outputs
  output logic const_latency_active,
  output logic [`PMRS_PF_THR_W-1:0] pf_threshold,
  output logic power_fail_warning_event,
  output logic nvm_write_block,
  // domain resets, active high
  output pmrs_domain_t domain_reset,
  // ram section control
  output pmrs_ram_t [RAM_SECTIONS-1:0] ram_ctrl
);

  localparam int HOLD_CYC_I = (`PMRS_RST_HOLD_NS + `PMRS_CLK_NS - 1) / `PMRS_CLK_NS;
  localparam logic [3:0] HOLD_CYC = 4'(HOLD_CYC_I);
  localparam int SYNC_W = NUM_PINS + 5;

  // two-flop synchronisers for everything off the ref_clk domain
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  always_ff @(posedge ref_clk) begin
    sync1_reg <= {pin_levels, supply_ok, regulators_ok, brownout_n,
                  supply_below_threshold, high_freq_clock_running};
    sync2_reg <= sync1_reg;
  end

  logic [NUM_PINS-1:0] pins_s;
  logic supply_ok_s;
  logic regs_ok_s;
  logic brownout_n_s;
  logic below_s;
  logic high_freq_clock_s;
  assign {pins_s, supply_ok_s, regs_ok_s, brownout_n_s, below_s, high_freq_clock_s} = sync2_reg;

  logic [31:0] pin_select_reg;
  logic [31:0] reason_reg;
  logic [31:0] pf_config_reg;
  logic pf_event_reg;
  logic const_lat_reg;
  logic [31:0] ram_reg [RAM_SECTIONS];
  pmrs_domain_t tgt_reg;
  logic [3:0] hold_cnt_reg;
  logic pf_cond_reg;

  // decoded writes
  logic wr_const_latency_task;
  logic wr_lowpower;
  logic wr_pfevt;
  logic wr_psel;
  logic wr_reason;
  logic wr_pfcfg;
  assign wr_const_latency_task = reg_wr && reg_addr == `PMRS_OFF_TASK_CONST_LATENCY_TASK && reg_wdata[0];
  assign wr_lowpower = reg_wr && reg_addr == `PMRS_OFF_TASK_LOWPOWER && reg_wdata[0];
  assign wr_pfevt = reg_wr && reg_addr == `PMRS_OFF_EVT_PFWARN;
  assign wr_psel = reg_wr && reg_addr == `PMRS_OFF_PIN_SELECT;
  assign wr_reason = reg_wr && reg_addr == `PMRS_OFF_RESET_REASON;
  assign wr_pfcfg = reg_wr && reg_addr == `PMRS_OFF_PF_CONFIG;

  // level sources
  logic por_lvl;
  logic pin_lvl;
  // (RULE_14) supply and regulators ready
  assign por_lvl = !supply_ok_s || !regs_ok_s || !brownout_n_s;
  // (RULE_15) capable, connected, selected pin
  assign pin_lvl = pin_select_reg[`PMRS_PSEL_CONNECT]
                   && RESET_PIN_CAPABLE[pin_select_reg[4:0]]
                   && !pins_s[pin_select_reg[4:0]];

  // pulsed sources, gated as the system state demands
  logic wdog_ev;
  logic lock_ev;
  logic soft_ev;
  logic wake_ev;
  // (RULE_20) no watchdog reset in System OFF
  assign wdog_ev = watchdog_timeout && !system_off;
  // (RULE_18) lockup ignored under debug
  assign lock_ev = cpu_lockup && !debug_mode && !system_off;
  // (RULE_17) core request or control port
  assign soft_ev = system_reset_request_bit || control_access_port_reset;
  assign wake_ev = wake_from_off && system_off;

  // target masks per source
  pmrs_domain_t ev_mask;
  pmrs_domain_t lvl_mask;
  always_comb begin
    ev_mask = '0;
    lvl_mask = '0;
    // (RULE_18) soft and lockup targets
    if (soft_ev || lock_ev) begin
      ev_mask.cpu = 1'b1;
      ev_mask.periph = 1'b1;
      ev_mask.gpio = 1'b1;
    end
    // (RULE_19) wake targets, (RULE_16) debug kept in debug mode
    if (wake_ev) begin
      ev_mask.cpu = 1'b1;
      ev_mask.periph = 1'b1;
      ev_mask.debug = ev_mask.debug || !debug_mode;
    end
    // (RULE_20) watchdog and pin targets
    if (wdog_ev || pin_lvl) begin
      ev_mask = ev_mask | 8'h3F;
    end
    if (pin_lvl) begin
      lvl_mask = 8'h3F;
    end
    // (RULE_21) brownout and power-on clear all
    if (por_lvl) begin
      lvl_mask = 8'hFF;
      ev_mask = 8'hFF;
    end
  end

  // pulsed resets stretched to a minimum length
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tgt_reg <= '0;
      hold_cnt_reg <= 4'h0;
    end else if (ev_mask != '0) begin
      tgt_reg <= (hold_cnt_reg != 4'h0) ? (tgt_reg | ev_mask) : ev_mask;
      hold_cnt_reg <= HOLD_CYC;
    end else if (hold_cnt_reg != 4'h0) begin
      hold_cnt_reg <= hold_cnt_reg - 4'h1;
    end else begin
      tgt_reg <= '0;
    end
  end

  // (RULE_01) released reset lands in System ON with all domains free
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      domain_reset <= 8'hFF;
    end else begin
      domain_reset <= tgt_reg | lvl_mask;
    end
  end

  // (RULE_13) sticky reason bits, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!nrst || por_lvl) begin
      reason_reg <= 32'h0000_0000;
    end else begin
      reason_reg <= (wr_reason ? (reason_reg & ~reg_wdata) : reason_reg)
                    | (32'(pin_lvl) << `PMRS_RR_PIN)
                    | (32'(wdog_ev) << `PMRS_RR_WDOG)
                    | (32'(system_reset_request_bit) << `PMRS_RR_SOFT)
                    | (32'(lock_ev) << `PMRS_RR_LOCKUP)
                    | (32'(wake_ev) << `PMRS_RR_WAKE)
                    | (32'(control_access_port_reset) << `PMRS_RR_CTRLAP);
    end
  end

  // (RULE_23) single mode bit, last task wins
  always_ff @(posedge ref_clk) begin
    // (RULE_05) wake or peripheral reset returns to low power
    if (!nrst || domain_reset.periph || wake_ev) begin
      const_lat_reg <= 1'b0;
    end else if (wr_const_latency_task) begin
      // (RULE_03) constant latency chosen
      const_lat_reg <= 1'b1;
    end else if (wr_lowpower) begin
      // (RULE_04) low power chosen
      const_lat_reg <= 1'b0;
    end
  end

  // (RULE_02) mode only bites while everything sleeps
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      const_latency_active <= 1'b0;
    end else begin
      const_latency_active <= const_lat_reg && cpu_idle && periph_idle && !system_off;
    end
  end

  // pin select survives all but power-on and brownout; a pin reset would cancel itself
  always_ff @(posedge ref_clk) begin
    if (!nrst || domain_reset.swdp) begin
      pin_select_reg <= `PMRS_PSEL_RST;
    end else if (wr_psel) begin
      pin_select_reg <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst || domain_reset.periph) begin
      pf_config_reg <= 32'h0000_0000;
    end else if (wr_pfcfg) begin
      pf_config_reg <= reg_wdata & 32'h0000_001F;
    end
  end

  // (RULE_10) comparator only runs in ON with the fast clock
  logic pf_cond;
  assign pf_cond = pf_config_reg[`PMRS_PF_EN] && high_freq_clock_s && !system_off && below_s;

  // (RULE_07) edge of the combined condition covers enable and threshold raise
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pf_cond_reg <= 1'b0;
    end else begin
      pf_cond_reg <= pf_cond;
    end
  end

  // (RULE_06) warning on falling supply; set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!nrst || domain_reset.periph) begin
      pf_event_reg <= 1'b0;
      power_fail_warning_event <= 1'b0;
    end else begin
      power_fail_warning_event <= pf_cond && !pf_cond_reg;
      if (pf_cond && !pf_cond_reg) begin
        pf_event_reg <= 1'b1;
      end else if (wr_pfevt && !reg_wdata[0]) begin
        pf_event_reg <= 1'b0;
      end
    end
  end

  // (RULE_09) write inhibit follows the condition; (RULE_08) it feeds no reset mask
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      nvm_write_block <= 1'b0;
      pf_threshold <= '0;
    end else begin
      nvm_write_block <= pf_cond;
      pf_threshold <= pf_config_reg[`PMRS_PF_THR_LSB +: `PMRS_PF_THR_W];
    end
  end

  // ram sections; (RULE_22) contents never touched, only control bits retained
  genvar g;
  generate
    for (g = 0; g < RAM_SECTIONS; g++) begin : g_ram
      localparam logic [`PMRS_ADDR_W-1:0] RAM_OFF =
        `PMRS_OFF_RAM_BASE + `PMRS_ADDR_W'(g) * `PMRS_RAM_STRIDE;
      always_ff @(posedge ref_clk) begin
        if (!nrst || domain_reset.retained) begin
          ram_reg[g] <= `PMRS_RAM_RST;
        end else if (reg_wr && reg_addr == RAM_OFF) begin
          ram_reg[g] <= reg_wdata & `PMRS_RAM_RST;
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          ram_ctrl[g] <= 2'b11;
        end else begin
          // (RULE_12) on: power gives access and retention
          // (RULE_11) off: no access, retention field alone
          ram_ctrl[g].ram_access <= !system_off && ram_reg[g][`PMRS_RAM_POWER];
          ram_ctrl[g].ram_retain <= ram_reg[g][`PMRS_RAM_RETAIN]
                                    || (!system_off && ram_reg[g][`PMRS_RAM_POWER]);
        end
      end
    end
  endgenerate

  // read port, data one cycle after the strobe, unmapped reads zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      `PMRS_OFF_EVT_PFWARN: rd_mux = {31'h0, pf_event_reg};
      `PMRS_OFF_PIN_SELECT: rd_mux = pin_select_reg;
      `PMRS_OFF_RESET_REASON: rd_mux = reason_reg;
      `PMRS_OFF_PF_CONFIG: rd_mux = pf_config_reg;
      `PMRS_OFF_STATUS: rd_mux = {29'h0, pf_cond, const_latency_active, const_lat_reg};
      default: begin
        for (int i = 0; i < RAM_SECTIONS; i++) begin
          if (reg_addr == `PMRS_OFF_RAM_BASE + `PMRS_ADDR_W'(i) * `PMRS_RAM_STRIDE) begin
            rd_mux = ram_reg[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // checks
  a_soft_targets: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_17
    soft_ev && !por_lvl && !pin_lvl && !wdog_ev && !wake_ev
    |=> ##1 domain_reset.cpu && domain_reset.gpio)
    else $error("soft reset did not reach cpu and gpio");
  a_lockup_debug: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_18
    cpu_lockup && debug_mode && !soft_ev && ev_mask == '0 |=> !reason_reg[`PMRS_RR_LOCKUP]
      || $past(reason_reg[`PMRS_RR_LOCKUP]))
    else $error("lockup recorded under debug");
  a_por_all: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_21
    por_lvl |=> domain_reset == 8'hFF)
    else $error("power-on level did not clear all domains");
  a_wake_keeps: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_16
    wake_ev && debug_mode && !por_lvl && !pin_lvl && !wdog_ev && !soft_ev
      && !lock_ev && hold_cnt_reg == 4'h0
    |=> ##1 !domain_reset.debug && !domain_reset.gpio && domain_reset.cpu)
    else $error("wake reset touched kept domains");
  a_mode_last: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_03
    wr_const_latency_task && !domain_reset.periph && !wake_ev |=> const_lat_reg)
    else $error("constant latency task ignored");
  a_mode_idle: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_02
    const_latency_active |-> $past(cpu_idle) && $past(periph_idle))
    else $error("sub mode active while busy");
  a_warn_pulse: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_06
    $rose(pf_cond) && !domain_reset.periph |=> power_fail_warning_event ##1
      !power_fail_warning_event)
    else $error("warning pulse wrong");
  a_nvm_block: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_10
    system_off || !high_freq_clock_s |=> !nvm_write_block)
    else $error("write block while comparator off");
  a_reason_keep: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_13
    wake_ev && !por_lvl |=> reason_reg[`PMRS_RR_WAKE])
    else $error("wake not recorded");
  a_wdog_off: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_20
    system_off && watchdog_timeout && !por_lvl |=> !reason_reg[`PMRS_RR_WDOG]
      || $past(reason_reg[`PMRS_RR_WDOG]))
    else $error("watchdog reset in System OFF");

  c_soft: cover property (@(posedge ref_clk) disable iff (!nrst) soft_ev ##2 domain_reset.cpu);
  c_warn: cover property (@(posedge ref_clk) disable iff (!nrst) power_fail_warning_event);
  c_wake: cover property (@(posedge ref_clk) disable iff (!nrst) wake_ev ##2 domain_reset.periph);
  c_const: cover property (@(posedge ref_clk) disable iff (!nrst) const_latency_active);

endmodule : pmrs_supervisor

`default_nettype wire

// ==== verification/pmrs_supervisor_tb.sv ====
// Purpose: self-checking bench for the power mode and reset supervisor
// Assumes: default parameters, all supplies good after reset, register port on ref_clk
// Notes: each scenario drives the ports and judges the result itself
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_defs.svh"

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, exp, got); end end

module pmrs_supervisor_tb;
  import pmrs_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic supply_ok = 1'b1;
  logic regulators_ok = 1'b1;
  logic brownout_n = 1'b1;
  logic below = 1'b0;
  logic high_freq_clock_on = 1'b1;
  logic [31:0] pin_levels = 32'hFFFF_FFFF;
  logic cpu_idle = 1'b1;
  logic periph_idle = 1'b1;
  logic system_off = 1'b0;
  logic wake = 1'b0;
  logic debug_mode = 1'b0;
  logic sys_req = 1'b0;
  logic cap_req = 1'b0;
  logic wdog = 1'b0;
  logic lockup = 1'b0;
  logic const_latency_active;
  logic [3:0] pf_threshold;
  logic power_fail_warning_event;
  logic nvm_write_block;
  pmrs_domain_t domain_reset;
  pmrs_ram_t [2:0] ram_ctrl;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // one-hot selects of the pulsed request inputs
  localparam logic [4:0] P_SOFT = 5'h01;
  localparam logic [4:0] P_CAP = 5'h02;
  localparam logic [4:0] P_WDOG = 5'h04;
  localparam logic [4:0] P_LOCK = 5'h08;
  localparam logic [4:0] P_WAKE = 5'h10;

  pmrs_supervisor pmrs_supervisor_i (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_ok(supply_ok),
    .regulators_ok(regulators_ok), .brownout_n(brownout_n),
    .supply_below_threshold(below), .high_freq_clock_running(high_freq_clock_on),
    .pin_levels(pin_levels), .cpu_idle(cpu_idle), .periph_idle(periph_idle),
    .system_off(system_off), .wake_from_off(wake), .debug_mode(debug_mode),
    .system_reset_request_bit(sys_req), .control_access_port_reset(cap_req),
    .watchdog_timeout(wdog), .cpu_lockup(lockup),
    .const_latency_active(const_latency_active), .pf_threshold(pf_threshold),
    .power_fail_warning_event(power_fail_warning_event),
    .nvm_write_block(nvm_write_block), .domain_reset(domain_reset), .ram_ctrl(ram_ctrl)
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // a hang anywhere ends the run as a mismatch
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd

  task automatic pulse(input logic [4:0] m);
    @(posedge ref_clk);
    {wake, lockup, wdog, cap_req, sys_req} <= m;
    @(posedge ref_clk);
    {wake, lockup, wdog, cap_req, sys_req} <= 5'h00;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle

  // waits a bounded time for any domain reset to show
  task automatic wait_dr();
    int n;
    n = 0;
    @(negedge ref_clk);
    while (domain_reset === 8'h00 && n < 12) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_dr

  // counts the cycles the reset stands, bounded
  task automatic wait_idle(output int n);
    n = 1;
    @(negedge ref_clk);
    while (domain_reset !== 8'h00 && n < 40) begin
      n++;
      @(negedge ref_clk);
    end
  endtask : wait_idle

  task automatic reason(input logic [31:0] exp, input string nm);
    logic [31:0] d;
    rd(`PMRS_OFF_RESET_REASON, d);
    `CHK(nm, exp, d)
    wr(`PMRS_OFF_RESET_REASON, 32'hFFFF_FFFF);
  endtask : reason

  task automatic t_power_on();
    logic [31:0] d;
    `CHK("dr_idle", 8'h00, domain_reset)
    `CHK("cl_po", 1'b0, const_latency_active)
    rd(`PMRS_OFF_RAM_BASE, d);
    `CHK("ram_rst", `PMRS_RAM_RST, d)
    rd(12'h7F0, d);
    `CHK("unmapped", 32'h0000_0000, d)
  endtask : t_power_on

  task automatic t_modes();
    wr(`PMRS_OFF_TASK_CONST_LATENCY_TASK, 32'h0000_0001);
    idle(2);
    `CHK("cl_on", 1'b1, const_latency_active)
    @(posedge ref_clk);
    cpu_idle <= 1'b0;
    idle(2);
    `CHK("cl_busy", 1'b0, const_latency_active)
    @(posedge ref_clk);
    cpu_idle <= 1'b1;
    idle(2);
    `CHK("cl_back", 1'b1, const_latency_active)
    wr(`PMRS_OFF_TASK_LOWPOWER, 32'h0000_0001);
    idle(2);
    `CHK("lp_on", 1'b0, const_latency_active)
    wr(`PMRS_OFF_TASK_CONST_LATENCY_TASK, 32'h0000_0001);
  endtask : t_modes

  task automatic t_soft();
    int n;
    pulse(P_SOFT);
    wait_dr();
    `CHK("dr_soft", 8'h07, domain_reset)
    wait_idle(n);
    `CHK("hold", 9, n)
    `CHK("cl_after", 1'b0, const_latency_active)
    reason(32'h0000_0004, "rr_soft");
    pulse(P_CAP);
    wait_dr();
    `CHK("dr_cap", 8'h07, domain_reset)
    wait_idle(n);
    reason(32'h0002_0000, "rr_cap");
  endtask : t_soft

  task automatic t_gated();
    debug_mode <= 1'b1;
    pulse(P_LOCK);
    idle(12);
    `CHK("lock_dbg", 8'h00, domain_reset)
    @(posedge ref_clk);
    debug_mode <= 1'b0;
    system_off <= 1'b1;
    pulse(P_WDOG);
    idle(12);
    `CHK("wd_off", 8'h00, domain_reset)
    @(posedge ref_clk);
    system_off <= 1'b0;
    reason(32'h0000_0000, "rr_none");
  endtask : t_gated

  task automatic t_lock_wdog();
    int n;
    pulse(P_LOCK);
    wait_dr();
    `CHK("dr_lock", 8'h07, domain_reset)
    wait_idle(n);
    reason(32'h0000_0008, "rr_lock");
    pulse(P_WDOG);
    wait_dr();
    `CHK("dr_wdog", 8'h3F, domain_reset)
    wait_idle(n);
    reason(32'h0000_0002, "rr_wdog");
  endtask : t_lock_wdog

  // wake from off, with and without debug
  task automatic t_wake();
    int n;
    system_off <= 1'b1;
    pulse(P_WAKE);
    wait_dr();
    `CHK("dr_wake", 8'h0B, domain_reset)
    wait_idle(n);
    @(posedge ref_clk);
    debug_mode <= 1'b1;
    pulse(P_WAKE);
    wait_dr();
    `CHK("dr_wake_dbg", 8'h03, domain_reset)
    wait_idle(n);
    @(posedge ref_clk);
    debug_mode <= 1'b0;
    system_off <= 1'b0;
    reason(32'h0001_0000, "rr_wake");
  endtask : t_wake

  task automatic t_pin();
    int n;
    wr(`PMRS_OFF_PIN_SELECT, 32'h8000_0000);
    pin_levels[0] <= 1'b0;
    wait_dr();
    `CHK("dr_pin", 8'h3F, domain_reset)
    idle(20);
    `CHK("pin_hold", 8'h3F, domain_reset)
    @(posedge ref_clk);
    pin_levels[0] <= 1'b1;
    wait_idle(n);
    reason(32'h0000_0001, "rr_pin");
  endtask : t_pin

  task automatic t_pfail();
    int ev;
    logic [31:0] d;
    below <= 1'b1;
    idle(4);
    wr(`PMRS_OFF_PF_CONFIG, 32'h0000_000B);
    ev = 0;
    repeat (8) begin
      @(negedge ref_clk);
      if (power_fail_warning_event === 1'b1) ev++;
    end
    `CHK("pf_events", 1, ev)
    `CHK("pf_thr", 4'h5, pf_threshold)
    `CHK("nvm_blk", 1'b1, nvm_write_block)
    `CHK("pf_norst", 8'h00, domain_reset)
    @(posedge ref_clk);
    high_freq_clock_on <= 1'b0;
    idle(5);
    `CHK("blk_noclk", 1'b0, nvm_write_block)
    @(posedge ref_clk);
    high_freq_clock_on <= 1'b1;
    below <= 1'b0;
    idle(5);
    `CHK("blk_above", 1'b0, nvm_write_block)
    // supply falling while the comparator is already enabled
    @(posedge ref_clk);
    below <= 1'b1;
    ev = 0;
    repeat (8) begin
      @(negedge ref_clk);
      if (power_fail_warning_event === 1'b1) ev++;
    end
    `CHK("pf_fall", 1, ev)
    rd(`PMRS_OFF_EVT_PFWARN, d);
    `CHK("pf_evt_reg", 32'h0000_0001, d)
    @(posedge ref_clk);
    below <= 1'b0;
  endtask : t_pfail

  task automatic t_ram();
    wr(`PMRS_OFF_RAM_BASE + 12'h020, 32'h0001_0000);
    idle(2);
    `CHK("ram_ret", 2'b01, ram_ctrl[2])
    wr(`PMRS_OFF_RAM_BASE + 12'h020, 32'h0000_0001);
    idle(2);
    `CHK("ram_pwr", 2'b11, ram_ctrl[2])
    @(posedge ref_clk);
    system_off <= 1'b1;
    idle(3);
    `CHK("ram_off", 2'b00, ram_ctrl[2])
    `CHK("ram_off0", 2'b01, ram_ctrl[0])
    @(posedge ref_clk);
    system_off <= 1'b0;
  endtask : t_ram

  task automatic t_brown();
    int n;
    reason(32'h0000_0000, "rr_pre");
    pulse(P_SOFT);
    wait_dr();
    wait_idle(n);
    @(posedge ref_clk);
    brownout_n <= 1'b0;
    wait_dr();
    `CHK("dr_bor", 8'hFF, domain_reset)
    idle(20);
    `CHK("bor_hold", 8'hFF, domain_reset)
    @(posedge ref_clk);
    brownout_n <= 1'b1;
    wait_idle(n);
    reason(32'h0000_0000, "rr_bor");
  endtask : t_brown

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    idle(4);
    t_power_on();
    t_modes();
    t_soft();
    t_gated();
    t_lock_wdog();
    t_wake();
    t_pin();
    t_pfail();
    t_ram();
    t_brown();
    finish_test();
  end
endmodule : pmrs_supervisor_tb

`default_nettype wire
